// >>> src/esm_pkg.sv
/*
 * esm_pkg: shared constants, types and decode helpers for the exception
 * state save and machine state word block.
 * Assumes: bit k of the architectural numbering (bit 0 is the most
 * significant) sits at vector index 31-k of every 32-bit word here.
 */
package esm_pkg;

    // register byte addresses on the register bus
    localparam logic [31:0] ESM_ADDR_MSW  = 32'h0000_0000;  // machine_state_word
    localparam logic [31:0] ESM_ADDR_SRA  = 32'h0000_0004;  // saved_return_address
    localparam logic [31:0] ESM_ADDR_SSW  = 32'h0000_0008;  // saved_state_word
    localparam logic [31:0] ESM_ADDR_STAT = 32'h0000_000c;  // block status, read only

    // machine_state_word field indices (vector index = 31 - architectural bit)
    localparam int unsigned ESM_LPW = 18;  // reduced_energy_mode, bit 13
    localparam int unsigned ESM_HBO = 16;  // handler_byte_order, bit 15
    localparam int unsigned ESM_IA  = 15;  // async_interrupt_allow, bit 16
    localparam int unsigned ESM_UM  = 14;  // user_mode_only, bit 17
    localparam int unsigned ESM_FA  = 13;  // float_available, bit 18
    localparam int unsigned ESM_MC  = 12;  // machine_check_allow, bit 19
    localparam int unsigned ESM_FTL = 11;  // float_trap_mode_low, bit 20
    localparam int unsigned ESM_SS  = 10;  // single_step_trace_on, bit 21
    localparam int unsigned ESM_BT  = 9;   // branch_trace_on, bit 22
    localparam int unsigned ESM_FTH = 8;   // float_trap_mode_high, bit 23
    localparam int unsigned ESM_VB  = 6;   // vector_high_base, bit 25
    localparam int unsigned ESM_FX  = 5;   // fetch_translate_on, bit 26
    localparam int unsigned ESM_DX  = 4;   // data_translate_on, bit 27
    localparam int unsigned ESM_RI  = 1;   // recoverable flag, bit 30
    localparam int unsigned ESM_RB  = 0;   // reversed_byte_order, bit 31

    // masks: exception-specific bits 1-4,10-15; copied bits 16-23,25-27,30-31
    localparam logic [31:0] ESM_SPEC_MASK = 32'h783f_0000;
    localparam logic [31:0] ESM_COPY_MASK = 32'h0000_ff73;
    localparam logic [31:0] ESM_WR_MASK   = 32'h0005_ff73;  // implemented bits
    localparam logic [31:0] ESM_EXC_KEEP  = 32'h0001_1040;  // handler order, check enable, base survive entry
    localparam logic [31:0] ESM_MSW_RST   = 32'h0000_0040;  // high vector base at reset
    localparam logic [31:0] ESM_SRA_RST   = 32'h0000_0000;
    localparam logic [31:0] ESM_SSW_RST   = 32'h0000_0000;
    localparam logic [31:0] ESM_NEXT_INSN = 32'h0000_0004;  // instruction size
    localparam logic [11:0] ESM_VEC_LO    = 12'h000;
    localparam logic [11:0] ESM_VEC_HI    = 12'hfff;
    localparam logic [1:0]  ESM_RESP_OKAY = 2'h0;
    localparam logic [1:0]  ESM_RESP_SLV  = 2'h2;

    typedef enum logic [2:0] {ESM_REG_MSW, ESM_REG_SRA, ESM_REG_SSW, ESM_REG_STAT, ESM_REG_NONE} esm_reg_t;
    typedef enum logic [1:0] {ESM_CAUSE_OTHER, ESM_CAUSE_SYSCALL, ESM_CAUSE_TRAP} esm_cause_t;

    typedef struct packed {
        esm_cause_t  cause;    // kind of exception
        logic [31:0] addr;     // address of the excepting instruction
        logic [19:0] vec_off;  // vector offset of this exception
        logic [31:0] info;     // exception-specific status bits
    } esm_exc_t;

    typedef struct packed {
        logic        is_fetch;  // 1 fetch side, 0 data side
        logic [31:0] addr;      // new saved_return_address
        logic [31:0] info;      // new saved_state_word
    } esm_mmu_upd_t;

    typedef struct packed {
        logic        awvalid;
        logic [31:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [31:0] araddr;
        logic        rready;
    } esm_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } esm_axi_rsp_t;

    // address to register select, shared by read and write paths
    function automatic esm_reg_t esm_reg_sel(input logic [31:0] addr);
        if (addr == ESM_ADDR_MSW) return ESM_REG_MSW;
        else if (addr == ESM_ADDR_SRA) return ESM_REG_SRA;
        else if (addr == ESM_ADDR_SSW) return ESM_REG_SSW;
        else if (addr == ESM_ADDR_STAT) return ESM_REG_STAT;
        else return ESM_REG_NONE;
    endfunction : esm_reg_sel

    // byte-lane merge of a write into an old word
    function automatic logic [31:0] esm_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) res[i*8 +: 8] = wd[i*8 +: 8];
        end
        return res;
    endfunction : esm_merge

endpackage : esm_pkg

// >>> src/esm_axil_slave.sv
/*
 * esm_axil_slave: register-bus front end, one write and one read at a time.
 * Assumes: a single master obeying the valid/ready rules; the parent
 * decodes the address and returns read data and error flags combinationally.
 */
`timescale 1ns/1ps
`default_nettype none
module esm_axil_slave import esm_pkg::*; (
    input  wire logic         sys_clk_in,
    input  wire logic         rst_n_in,
    input  wire esm_axi_req_t axi_req_in,
    output esm_axi_rsp_t      axi_rsp_out,
    output logic              wr_en_out,
    output logic [31:0]       wr_addr_out,
    output logic [31:0]       wr_data_out,
    output logic [3:0]        wr_strb_out,
    input  wire logic         wr_err_in,
    output logic [31:0]       rd_addr_out,
    input  wire logic [31:0]  rd_data_in,
    input  wire logic         rd_err_in
);
    logic        aw_held_ff;
    logic        w_held_ff;
    logic [31:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0]  wstrb_ff;
    logic        bvalid_ff;
    logic [1:0]  bresp_ff;
    logic        rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  rresp_ff;
    logic        aw_fire;
    logic        w_fire;
    logic        ar_fire;

    // channel handshakes; address and data may come in either order
    assign aw_fire   = axi_req_in.awvalid && !aw_held_ff && !bvalid_ff;
    assign w_fire    = axi_req_in.wvalid && !w_held_ff && !bvalid_ff;
    assign ar_fire   = axi_req_in.arvalid && !rvalid_ff;
    assign wr_en_out = aw_held_ff && w_held_ff && !bvalid_ff;

    assign wr_addr_out = awaddr_ff;
    assign wr_data_out = wdata_ff;
    assign wr_strb_out = wstrb_ff;
    assign rd_addr_out = axi_req_in.araddr;

    assign axi_rsp_out.awready = !aw_held_ff && !bvalid_ff;
    assign axi_rsp_out.wready  = !w_held_ff && !bvalid_ff;
    assign axi_rsp_out.bvalid  = bvalid_ff;
    assign axi_rsp_out.bresp   = bresp_ff;
    assign axi_rsp_out.arready = !rvalid_ff;
    assign axi_rsp_out.rvalid  = rvalid_ff;
    assign axi_rsp_out.rdata   = rdata_ff;
    assign axi_rsp_out.rresp   = rresp_ff;

    // write side: capture both halves, then answer one cycle later
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            awaddr_ff  <= 32'h0000_0000;
            wdata_ff   <= 32'h0000_0000;
            wstrb_ff   <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= ESM_RESP_OKAY;
        end else begin
            if (aw_fire) awaddr_ff <= axi_req_in.awaddr;
            if (w_fire) wdata_ff <= axi_req_in.wdata;
            if (w_fire) wstrb_ff <= axi_req_in.wstrb;
            aw_held_ff <= (aw_held_ff || aw_fire) && !wr_en_out;
            w_held_ff  <= (w_held_ff || w_fire) && !wr_en_out;
            if (wr_en_out) begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= wr_err_in ? ESM_RESP_SLV : ESM_RESP_OKAY;
            end else if (axi_req_in.bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // read side: data registered on the address handshake
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= ESM_RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_data_in;
            rresp_ff  <= rd_err_in ? ESM_RESP_SLV : ESM_RESP_OKAY;
        end else if (axi_req_in.rready) begin
            rvalid_ff <= 1'b0;
        end
    end

endmodule : esm_axil_slave
`default_nettype wire

// >>> src/esm_core.sv
/*
 * esm_core: exception entry state save, return from interrupt and the
 * machine state word with the controls it drives into the core.
 * Assumes: the pipeline raises exceptions through exc_valid_in and reports
 * drain state; software reaches the registers over the register bus.
 */
// Function
// - exception entry loads saved word bits 1-4 and 10-15 from exception info
// - exception entry copies state bits 16-23, 25-27, 30-31 into saved word
// - resume address is excepting instruction, or next one for system call/trap
// - take only with older work complete and nothing younger started
// - return-from-interrupt restores state word from saved word
// - translated fetches or data accesses may rewrite both save registers
// - state word is 32 bits, low half of the 64-bit word
// - bit 13 selects reduced power mode when set
// - bit 15 is copied into byte order bit on exception entry
// - bit 16 clear delays external and decrementer interrupts
// - bit 17 set restricts execution to user-level instructions
// - bit 18 clear blocks dispatch of all floating-point instructions
// - bit 19 enables machine check; otherwise checkstop
// - bits 20 and 23 hold floating-point exception mode
// - bit 21 set raises single-step trace after next completed instruction
// - bit 22 set raises branch trace after any completed branch
// - bit 25 selects zero or all-ones vector prefix
// - bit 31 selects big-endian when clear, little-endian when set
// - every exception clears both translation enables
// - every exception clears the asynchronous interrupt enable
// - fetch resumes at vector offset added to selected base
`timescale 1ns/1ps
`default_nettype none
module esm_core import esm_pkg::*; (
    input  wire logic         sys_clk_in,
    input  wire logic         rst_n_in,
    input  wire esm_axi_req_t axi_req_in,
    output esm_axi_rsp_t      axi_rsp_out,
    input  wire logic         exc_valid_in,
    input  wire esm_exc_t     exc_in,
    input  wire logic         pipe_drained_in,
    output logic              exc_ready_out,
    output logic              hold_issue_out,
    input  wire logic         rfi_in,
    input  wire logic         mmu_upd_valid_in,
    input  wire esm_mmu_upd_t mmu_upd_in,
    input  wire logic         ext_irq_in,
    input  wire logic         dec_irq_in,
    output logic              async_req_out,
    input  wire logic         mchk_in,
    output logic              mchk_take_out,
    output logic              checkstop_out,
    input  wire logic         instr_done_in,
    input  wire logic         instr_is_branch_in,
    output logic              sstep_trap_out,
    output logic              branch_trap_out,
    output logic              redirect_valid_out,
    output logic [31:0]       redirect_addr_out,
    output logic              user_mode_out,
    output logic              fp_dispatch_ok_out,
    output logic [1:0]        fp_trap_mode_out,
    output logic              low_power_out,
    output logic              little_endian_out,
    output logic              fetch_xlate_out,
    output logic              data_xlate_out
);
    logic [31:0] msw_ff;
    logic [31:0] sra_ff;
    logic [31:0] ssw_ff;
    logic [31:0] nxt_msw;
    logic [31:0] nxt_sra;
    logic [31:0] nxt_ssw;
    logic        redir_v_ff;
    logic [31:0] redir_a_ff;
    logic [31:0] nxt_redir_a;
    logic        chk_ff;
    logic        sstep_ff;
    logic        btrace_ff;
    logic        wr_en;
    logic [31:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic [31:0] rd_addr;
    logic [31:0] rd_data;
    esm_reg_t    wr_sel;
    esm_reg_t    rd_sel;
    logic        take;
    logic        do_rfi;
    logic        mmu_ok;
    logic        sw_msw;
    logic        sw_sra;
    logic        sw_ssw;
    logic        next_insn;
    logic [31:0] resume_addr;
    logic [31:0] save_word;
    logic [31:0] entry_msw;
    logic [31:0] vec_addr;
    logic [31:0] stat_word;

    // register bus front end
    esm_axil_slave u_bus (
        .sys_clk_in  (sys_clk_in),
        .rst_n_in    (rst_n_in),
        .axi_req_in  (axi_req_in),
        .axi_rsp_out (axi_rsp_out),
        .wr_en_out   (wr_en),
        .wr_addr_out (wr_addr),
        .wr_data_out (wr_data),
        .wr_strb_out (wr_strb),
        .wr_err_in   (wr_sel == ESM_REG_NONE || wr_sel == ESM_REG_STAT),
        .rd_addr_out (rd_addr),
        .rd_data_in  (rd_data),
        .rd_err_in   (rd_sel == ESM_REG_NONE)
    );

    // address decode for both directions
    assign wr_sel = esm_reg_sel(wr_addr);
    assign rd_sel = esm_reg_sel(rd_addr);

    assign exc_ready_out  = pipe_drained_in;
    assign hold_issue_out = exc_valid_in;
    assign take           = exc_valid_in && pipe_drained_in;

    // lower-priority updaters lose to an exception in the same cycle
    assign do_rfi = rfi_in && !take;
    assign mmu_ok = mmu_upd_valid_in && !take && !do_rfi
                    && (mmu_upd_in.is_fetch ? msw_ff[ESM_FX] : msw_ff[ESM_DX]);
    assign sw_msw = wr_en && wr_sel == ESM_REG_MSW && !take && !do_rfi;
    assign sw_sra = wr_en && wr_sel == ESM_REG_SRA && !take && !mmu_ok;
    assign sw_ssw = wr_en && wr_sel == ESM_REG_SSW && !take && !mmu_ok;

    assign next_insn   = exc_in.cause == ESM_CAUSE_SYSCALL || exc_in.cause == ESM_CAUSE_TRAP;
    assign resume_addr = next_insn ? exc_in.addr + ESM_NEXT_INSN : exc_in.addr;

    assign save_word = (exc_in.info & ESM_SPEC_MASK) | (msw_ff & ESM_COPY_MASK);

    assign entry_msw = (msw_ff & ESM_EXC_KEEP) | {31'h0000_0000, msw_ff[ESM_HBO]};

    assign vec_addr = {msw_ff[ESM_VB] ? ESM_VEC_HI : ESM_VEC_LO, exc_in.vec_off};

    // next state word, restore and writes masked
    assign nxt_msw = take   ? entry_msw
                   : do_rfi ? (ssw_ff & ESM_WR_MASK)
                   : sw_msw ? (esm_merge(msw_ff, wr_data, wr_strb) & ESM_WR_MASK)
                   : msw_ff;

    // next save registers
    assign nxt_sra = take   ? resume_addr
                   : mmu_ok ? mmu_upd_in.addr
                   : sw_sra ? esm_merge(sra_ff, wr_data, wr_strb)
                   : sra_ff;
    assign nxt_ssw = take   ? save_word
                   : mmu_ok ? mmu_upd_in.info
                   : sw_ssw ? esm_merge(ssw_ff, wr_data, wr_strb)
                   : ssw_ff;

    // redirect target: handler vector or saved return point
    assign nxt_redir_a = take ? vec_addr : do_rfi ? sra_ff : redir_a_ff;

    // architectural registers
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            msw_ff <= ESM_MSW_RST;
            sra_ff <= ESM_SRA_RST;
            ssw_ff <= ESM_SSW_RST;
        end else begin
            msw_ff <= nxt_msw;
            sra_ff <= nxt_sra;
            ssw_ff <= nxt_ssw;
        end
    end

    // fetch redirect, one-cycle pulse with held address
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            redir_v_ff <= 1'b0;
            redir_a_ff <= 32'h0000_0000;
        end else begin
            redir_v_ff <= take || do_rfi;
            redir_a_ff <= nxt_redir_a;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            chk_ff    <= 1'b0;
            sstep_ff  <= 1'b0;
            btrace_ff <= 1'b0;
        end else begin
            chk_ff    <= chk_ff || (mchk_in && !msw_ff[ESM_MC]);
            sstep_ff  <= instr_done_in && msw_ff[ESM_SS] && !take;
            btrace_ff <= instr_done_in && instr_is_branch_in && msw_ff[ESM_BT] && !take;
        end
    end

    assign async_req_out = (ext_irq_in || dec_irq_in) && msw_ff[ESM_IA] && !chk_ff;
    assign mchk_take_out = mchk_in && msw_ff[ESM_MC] && !chk_ff;
    assign checkstop_out = chk_ff;
    assign sstep_trap_out  = sstep_ff;
    assign branch_trap_out = btrace_ff;
    assign redirect_valid_out = redir_v_ff;
    assign redirect_addr_out  = redir_a_ff;

    assign low_power_out      = msw_ff[ESM_LPW];
    assign user_mode_out      = msw_ff[ESM_UM];
    assign fp_dispatch_ok_out = msw_ff[ESM_FA];
    assign fp_trap_mode_out   = {msw_ff[ESM_FTL], msw_ff[ESM_FTH]};
    assign little_endian_out  = msw_ff[ESM_RB];
    assign fetch_xlate_out    = msw_ff[ESM_FX];
    assign data_xlate_out     = msw_ff[ESM_DX];

    // status and full 32-bit read mux
    assign stat_word = {29'h0000_0000, exc_valid_in && !pipe_drained_in, async_req_out, chk_ff};
    assign rd_data   = rd_sel == ESM_REG_MSW  ? msw_ff
                     : rd_sel == ESM_REG_SRA  ? sra_ff
                     : rd_sel == ESM_REG_SSW  ? ssw_ff
                     : rd_sel == ESM_REG_STAT ? stat_word
                     : 32'h0000_0000;

    // checks on the state machinery
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    spec_bits_saved_a:
    assert property (take |=> (ssw_ff & ESM_SPEC_MASK) == ($past(exc_in.info) & ESM_SPEC_MASK))
        else $error("exception info bits not saved");

    state_bits_copied_a:
    assert property (take |=> (ssw_ff & ESM_COPY_MASK) == ($past(msw_ff) & ESM_COPY_MASK))
        else $error("state bits not copied to saved word");

    resume_point_a:
    assert property (take && next_insn |=> sra_ff == $past(exc_in.addr) + ESM_NEXT_INSN)
        else $error("system call resume address wrong");

    drain_gate_a:
    assert property (exc_valid_in && !pipe_drained_in && !rfi_in |=> !redirect_valid_out)
        else $error("exception taken before pipeline drained");

    rfi_restore_a:
    assert property (rfi_in && !take |=> msw_ff == ($past(ssw_ff) & ESM_WR_MASK) && redirect_valid_out)
        else $error("state not restored on return");

    entry_clears_a:
    assert property (take |=> !msw_ff[ESM_FX] && !msw_ff[ESM_DX] && !msw_ff[ESM_IA]
                     && msw_ff[ESM_RB] == $past(msw_ff[ESM_HBO]))
        else $error("handler entry state wrong");

    vector_target_a:
    assert property (take |=> redirect_valid_out
                     && redirect_addr_out[19:0] == $past(exc_in.vec_off)
                     && redirect_addr_out[31:20] == ($past(msw_ff[ESM_VB]) ? ESM_VEC_HI : ESM_VEC_LO))
        else $error("vector address wrong");

    reserved_zero_a:
    assert property ((msw_ff & ~ESM_WR_MASK) == 32'h0000_0000)
        else $error("reserved state bit set");

    async_mask_a:
    assert property (!msw_ff[ESM_IA] |-> !async_req_out)
        else $error("interrupt requested while masked");

    single_step_a:
    assert property (instr_done_in && msw_ff[ESM_SS] && !take |=> sstep_trap_out
                     ##1 (!sstep_trap_out || $past(instr_done_in)))
        else $error("single step trace missing");

    checkstop_stick_a:
    assert property (mchk_in && !msw_ff[ESM_MC] |=> checkstop_out [*2])
        else $error("checkstop not entered");

    cov_syscall_c: cover property (take && exc_in.cause == ESM_CAUSE_SYSCALL);
    cov_rfi_c: cover property (take ##[1:20] rfi_in);
    cov_mmu_c: cover property (mmu_ok);
    cov_stall_c: cover property (exc_valid_in && !pipe_drained_in ##1 take);

endmodule : esm_core
`default_nettype wire

// >>> dv/esm_pipe_model.sv
/* esm_pipe_model: pipeline-side exception source for the bench.
   Assumes the block takes a request at an edge where ready is high. */
`timescale 1ns/1ps
`default_nettype none
module esm_pipe_model import esm_pkg::*; (
    input  wire logic clk_in,
    input  wire logic ready_in,
    output logic      vld_out,
    output var esm_exc_t exc_out,
    output logic      drained_out
);
    // idle: no request, pipeline drained
    initial begin
        vld_out = 1'b0;
        exc_out = '0;
        drained_out = 1'b1;
    end
    // raise one exception, drain after slow cycles, hold until taken
    task automatic raise(input esm_exc_t e, input int slow);
        logic r;
        @(posedge clk_in);
        vld_out <= 1'b1;
        exc_out <= e;
        drained_out <= (slow == 0);
        if (slow > 0) begin
            repeat (slow) @(posedge clk_in);
            drained_out <= 1'b1;
        end
        do begin
            @(negedge clk_in);
            r = ready_in;
            @(posedge clk_in);
        end while (!r);
        vld_out <= 1'b0;
        exc_out <= ~e;  // released payload is not kept
    endtask : raise
endmodule : esm_pipe_model
`default_nettype wire

// >>> dv/exception_state_save_msr_bench.sv
/* exception_state_save_msr_bench: self-checking bench for esm_core.
   Assumes esm_pkg and esm_pipe_model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module exception_state_save_msr_bench import esm_pkg::*;;
    logic         sys_clk_in, rst_n_in, rfi, mmu_v, ext, dec, mchk, done, br, exc_v, drained, rdy;
    logic         rv, sst, btr, chs, mtk, areq, um, fpok, lp, lend, fx, dx, hold;
    logic [1:0]   ftm, r;
    logic [31:0]  raddr, m_msw, m_sra, m_ssw, d;
    esm_axi_req_t rq;
    esm_axi_rsp_t rs;
    esm_mmu_upd_t mmu;
    esm_exc_t     ex, exd;
    int           error_cnt, check_count;
    esm_core esm_core_inst(.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .axi_req_in(rq), .axi_rsp_out(rs),
        .exc_valid_in(exc_v), .exc_in(exd), .pipe_drained_in(drained), .exc_ready_out(rdy), .hold_issue_out(hold),
        .rfi_in(rfi), .mmu_upd_valid_in(mmu_v), .mmu_upd_in(mmu), .ext_irq_in(ext), .dec_irq_in(dec),
        .async_req_out(areq), .mchk_in(mchk), .mchk_take_out(mtk), .checkstop_out(chs), .instr_done_in(done),
        .instr_is_branch_in(br), .sstep_trap_out(sst), .branch_trap_out(btr), .redirect_valid_out(rv),
        .redirect_addr_out(raddr), .user_mode_out(um), .fp_dispatch_ok_out(fpok), .fp_trap_mode_out(ftm),
        .low_power_out(lp), .little_endian_out(lend), .fetch_xlate_out(fx), .data_xlate_out(dx));
    esm_pipe_model esm_pipe_model_inst(.clk_in(sys_clk_in), .ready_in(rdy), .vld_out(exc_v), .exc_out(exd),
        .drained_out(drained));
    // clock and watchdog
    initial begin
        sys_clk_in = 1'b0;
        forever #2.5 sys_clk_in = ~sys_clk_in;
    end
    initial begin
        #50us;
        error_cnt++;
        test_done();
    end
    task automatic test_done();
        if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : test_done
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // bus write: both channels offered, each released when taken
    task automatic wr(input logic [31:0] a, input logic [31:0] dt, output logic [1:0] rp);
        logic ta, tw, ga, gw, b;
        @(posedge sys_clk_in);
        rq.awaddr <= a;
        rq.wdata <= dt;
        rq.wstrb <= 4'hf;
        rq.awvalid <= 1'b1;
        rq.wvalid <= 1'b1;
        ta = 1'b0;
        tw = 1'b0;
        while (!(ta && tw)) begin
            @(negedge sys_clk_in);
            ga = rq.awvalid && rs.awready;
            gw = rq.wvalid && rs.wready;
            @(posedge sys_clk_in);
            if (ga) rq.awvalid <= 1'b0;
            if (gw) rq.wvalid <= 1'b0;
            ta |= ga;
            tw |= gw;
        end
        rq.bready <= 1'b1;
        do begin
            @(negedge sys_clk_in);
            b = rs.bvalid;
            rp = rs.bresp;
            @(posedge sys_clk_in);
        end while (!b);
        rq.bready <= 1'b0;
        chk("bresp", 32'(a >= ESM_ADDR_STAT ? ESM_RESP_SLV : ESM_RESP_OKAY), 32'(rp));
    endtask : wr
    // bus read and compare
    task automatic rchk(input string n, input logic [31:0] a, input logic [31:0] e);
        logic t, v;
        logic [31:0] q;
        logic [1:0]  rr;
        @(posedge sys_clk_in);
        rq.araddr <= a;
        rq.arvalid <= 1'b1;
        rq.rready <= 1'b1;
        do begin
            @(negedge sys_clk_in);
            t = rq.arvalid && rs.arready;
            v = rs.rvalid;
            q = rs.rdata;
            rr = rs.rresp;
            @(posedge sys_clk_in);
            if (t) rq.arvalid <= 1'b0;
        end while (!v);
        rq.rready <= 1'b0;
        chk(n, e, q);
        chk("rresp", 32'(a > ESM_ADDR_STAT ? ESM_RESP_SLV : ESM_RESP_OKAY), 32'(rr));
    endtask : rchk
    // control outputs against the model state word
    task automatic outs();
        chk("ctl", 32'({m_msw[ESM_UM], m_msw[ESM_FA], m_msw[ESM_FTL], m_msw[ESM_FTH], m_msw[ESM_LPW],
            m_msw[ESM_RB], m_msw[ESM_FX], m_msw[ESM_DX], m_msw[ESM_IA] & (ext | dec)}),
            32'({um, fpok, ftm, lp, lend, fx, dx, areq}));
    endtask : outs
    // main sequence
    initial begin
        {rq, rfi, mmu_v, mmu, ext, dec, mchk, done, br, rst_n_in} = '0;
        void'($urandom(32'h9494));
        repeat (4) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        m_msw = ESM_MSW_RST;
        rchk("msw", ESM_ADDR_MSW, m_msw);
        rchk("ssw", ESM_ADDR_SSW, 32'h0);
        wr(ESM_ADDR_MSW, 32'hffff_ffff, r);
        ext <= 1'b1;
        m_msw = ESM_WR_MASK;
        rchk("msw", ESM_ADDR_MSW, m_msw);
        @(negedge sys_clk_in);
        outs();
        wr(32'h10, 32'h1, r);
        chk("resp", 32'(ESM_RESP_SLV), 32'(r));
        wr(ESM_ADDR_STAT, 32'h7, r);
        rchk("unmapped", 32'h10, 32'h0);
        @(posedge sys_clk_in);
        done <= 1'b1;
        br <= 1'b1;
        @(posedge sys_clk_in);
        done <= 1'b0;
        @(negedge sys_clk_in);
        chk("trace", 32'h3, 32'({sst, btr}));
        for (int i = 0; i < 3; i++) begin
            d = $urandom;
            wr(ESM_ADDR_MSW, d, r);
            m_msw = d & ESM_WR_MASK;
            ex = {esm_cause_t'(i), $urandom, 20'($urandom), $urandom};
            fork
                esm_pipe_model_inst.raise(ex, i);
                begin
                    repeat (2) @(negedge sys_clk_in);
                    chk("hold", 32'h1, 32'(hold));
                end
            join
            m_ssw = (ex.info & ESM_SPEC_MASK) | (m_msw & ESM_COPY_MASK);
            m_sra = ex.addr + ((i > 0) ? ESM_NEXT_INSN : 32'h0);
            @(negedge sys_clk_in);
            chk("vector", {m_msw[ESM_VB] ? ESM_VEC_HI : ESM_VEC_LO, ex.vec_off}, raddr);
            chk("redir", 32'h1, 32'(rv));
            d = m_msw;
            m_msw = d & ESM_EXC_KEEP;
            m_msw[ESM_RB] = d[ESM_HBO];
            outs();
            rchk("ssw", ESM_ADDR_SSW, m_ssw);
            rchk("sra", ESM_ADDR_SRA, m_sra);
            rchk("msw", ESM_ADDR_MSW, m_msw);
            @(posedge sys_clk_in);
            rfi <= 1'b1;
            @(posedge sys_clk_in);
            rfi <= 1'b0;
            @(negedge sys_clk_in);
            chk("rfi", m_sra, raddr);
            chk("rfi_v", 32'h1, 32'(rv));
            m_msw = m_ssw & ESM_WR_MASK;
            rchk("msw", ESM_ADDR_MSW, m_msw);
            mmu <= {1'($urandom), $urandom, $urandom};
            mmu_v <= 1'b1;
            dec <= 1'($urandom);
            @(posedge sys_clk_in);
            mmu_v <= 1'b0;
            if (mmu.is_fetch ? m_msw[ESM_FX] : m_msw[ESM_DX]) begin
                m_sra = mmu.addr;
                m_ssw = mmu.info;
            end
            rchk("sra", ESM_ADDR_SRA, m_sra);
            rchk("ssw", ESM_ADDR_SSW, m_ssw);
        end
        mchk <= 1'b1;
        @(negedge sys_clk_in);
        chk("mchk", 32'(m_msw[ESM_MC]), 32'(mtk));
        wr(ESM_ADDR_MSW, 32'h0, r);
        @(negedge sys_clk_in);
        chk("stop", 32'h2, 32'({chs, mtk}));
        rchk("stat", ESM_ADDR_STAT, 32'h1);
        test_done();
    end
endmodule : exception_state_save_msr_bench
`default_nettype wire
